// File: verilog/fsg_cfg.svh
// Constants of the flash segment write guard: layout, offsets, resets.
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// ----------------------------------------------------------------------
// Flash geometry
// ----------------------------------------------------------------------
`define FSG_ADDR_W    17
`define FSG_PAGE_LSB  9
`define FSG_PTR_W     8
`define FSG_LAST_PAGE 8'hff
`define FSG_CFG_ADDR  17'h1ffff

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define FSG_CFG_W     16
`define FSG_BSEL_BIT  8
`define FSG_LPG_BIT   9
`define FSG_OFF_BIT   10
`define FSG_WG_BIT    11
`define FSG_RG_BIT    12
`define FSG_CFG_RST   16'h1fff

// ----------------------------------------------------------------------
// Register offsets and status bits
// ----------------------------------------------------------------------
`define FSG_REG_CFG   8'h00
`define FSG_REG_STAT  8'h04
`define FSG_REG_MASK  8'h08
`define FSG_REG_UPSET 8'h0c
`define FSG_REG_LAST  8'h10
`define FSG_ST_W      3
`define FSG_ST_BLK    0
`define FSG_ST_PERR   1
`define FSG_ST_LOAD   2

`endif

// File: verilog/fsg_pkg.sv
// Types and shared decoding of the flash segment write guard.
`default_nettype none
`include "fsg_cfg.svh"
package fsg_pkg;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSG_INT_WR = 2'h0,
    FSG_EXT_WR = 2'h1,
    FSG_EXT_RD = 2'h2
  } fsg_kind_t;

  // Gray order along fetch, wait, run.
  typedef enum logic [1:0] {
    FSG_S_FETCH = 2'h0,
    FSG_S_WAIT  = 2'h1,
    FSG_S_RUN   = 2'h3
  } fsg_state_t;

  // ----------------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`FSG_CFG_W-1:0] val;
    logic [`FSG_CFG_W-1:0] shd;
  } fsg_shadow_t;

  typedef struct packed {
    fsg_state_t             st;
    logic                   rd;
    logic [`FSG_ADDR_W-1:0] fa;
    logic                   ack;
    logic [31:0]            dat;
    logic                   rdy;
    logic                   done;
    logic                   blk;
    logic [`FSG_ST_W-1:0]   stat;
    logic [`FSG_ST_W-1:0]   mask;
    logic                   irq;
    logic                   drst;
    logic [`FSG_ADDR_W-1:0] last;
  } fsg_top_t;

  // Page number of a flash word address.
  function automatic logic [`FSG_PTR_W-1:0] fsg_page(
    input logic [`FSG_ADDR_W-1:0] a
  );
    fsg_page = a[`FSG_ADDR_W-1:`FSG_PAGE_LSB];
  endfunction : fsg_page

endpackage : fsg_pkg
`default_nettype wire

// File: verilog/fsg_shadow_cmp.sv
// Configuration register with complemented shadow copy and comparator.
`timescale 1ns/100ps
`default_nettype none
`include "fsg_cfg.svh"
module fsg_shadow_cmp
  import fsg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  load_i,
  input  wire logic [`FSG_CFG_W-1:0] data_i,
  input  wire logic [`FSG_CFG_W-1:0] upset_i,
  output logic      [`FSG_CFG_W-1:0] cfg_o,
  output logic                       mismatch_o
);

  fsg_shadow_t           s_ff;
  fsg_shadow_t           nxt_s;
  logic [`FSG_CFG_W-1:0] same;

  // ----------------------------------------------------------------------
  // Load and upset
  // ----------------------------------------------------------------------
  // load from flash. keep complement.
  always_comb begin
    nxt_s = s_ff;
    if (load_i) begin
      nxt_s.val = data_i;
      nxt_s.shd = ~data_i;
    end else begin
      // Upset touches only the live copy, as a cell disruption would.
      nxt_s.val = s_ff.val ^ upset_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff.val <= `FSG_CFG_RST;
      s_ff.shd <= ~`FSG_CFG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Continuous compare
  // ----------------------------------------------------------------------
  // bitwise compare, a bit equal to its shadow is corrupt.
  for (genvar gi = 0; gi < `FSG_CFG_W; gi++) begin : g_cmp
    assign same[gi] = s_ff.val[gi] ~^ s_ff.shd[gi];
  end
  assign mismatch_o = |same;
  assign cfg_o      = s_ff.val;

  a_load_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i |=> cfg_o == $past(data_i) && !mismatch_o)
    else $error("config not loaded with shadow");
  a_upset_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (!load_i && upset_i != '0) |=> mismatch_o)
    else $error("disturbed config bit not seen");

endmodule : fsg_shadow_cmp
`default_nettype wire

// File: verilog/fsg_range_chk.sv
// Combinational protection decision for one flash request.
`timescale 1ns/100ps
`default_nettype none
`include "fsg_cfg.svh"
module fsg_range_chk
  import fsg_pkg::*;
(
  input  wire logic [`FSG_CFG_W-1:0]  cfg_i,
  input  wire logic [`FSG_ADDR_W-1:0] addr_i,
  input  wire logic [1:0]             kind_i,
  output logic                        block_o
);

  logic [`FSG_PTR_W-1:0] pg;
  logic [`FSG_PTR_W-1:0] ptr;
  logic                  wr;
  logic                  seg;
  logic                  gen;

  // ----------------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------------
  // Segment and general terms are OR-ed so the segment only adds.
  always_comb begin
    pg  = fsg_page(addr_i);
    ptr = cfg_i[`FSG_PTR_W-1:0];
    wr  = (kind_i != FSG_EXT_RD);
    if (cfg_i[`FSG_OFF_BIT]) begin
      seg = 1'b0;
    // pointer page up to the top.
    end else if (cfg_i[`FSG_BSEL_BIT]) begin
      seg = (pg >= ptr);
    // bottom through pointer, plus last page while the LPG bit is clear.
    end else begin
      seg = (pg <= ptr) |
            (!cfg_i[`FSG_LPG_BIT] && pg == `FSG_LAST_PAGE);
    end
    // write guard blocks all internal writes and erases.
    gen = (kind_i == FSG_INT_WR) && !cfg_i[`FSG_WG_BIT];
    // read guard blocks all external access.
    gen = gen | ((kind_i != FSG_INT_WR) && cfg_i[`FSG_RG_BIT]);
    // read guard also shields the configuration word.
    gen = gen | (wr && cfg_i[`FSG_RG_BIT] && addr_i == `FSG_CFG_ADDR);
    block_o = (wr & seg) | gen;
  end

endmodule : fsg_range_chk
`default_nettype wire

// File: verilog/fsg_guard.sv
// Flash segment write guard: loader, request checker and register slave.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "fsg_cfg.svh"
module fsg_guard
  import fsg_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone classic slave.
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Configuration word fetch from flash.
  output logic                        flash_rd_o,
  output logic      [`FSG_ADDR_W-1:0] flash_addr_o,
  input  wire logic                   flash_rd_ack_i,
  input  wire logic [`FSG_CFG_W-1:0]  flash_rd_data_i,
  // Write, erase and read requests from the flash controller.
  input  wire logic                   req_valid_i,
  input  wire logic [`FSG_ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]             req_kind_i,
  output logic                        req_ready_o,
  output logic                        req_done_o,
  output logic                        req_block_o,
  // System side.
  output logic                        dev_reset_o,
  output logic                        irq_o
);

  fsg_top_t              s_ff;
  fsg_top_t              nxt_s;
  logic [`FSG_CFG_W-1:0] cfg;
  logic                  mism;
  logic                  dec_block;
  logic                  take;
  logic                  acc;
  logic                  load;
  logic                  rd_stat;
  logic [`FSG_CFG_W-1:0] upset;
  logic [`FSG_ST_W-1:0]  ev;

  // ----------------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------------
  // The shadow pair lives apart so that its compare stays local.
  fsg_shadow_cmp u_shadow (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (load),
    .data_i     (flash_rd_data_i),
    .upset_i    (upset),
    .cfg_o      (cfg),
    .mismatch_o (mism)
  );

  // ----------------------------------------------------------------------
  // Protection decision
  // ----------------------------------------------------------------------
  fsg_range_chk u_chk (
    .cfg_i   (cfg),
    .addr_i  (req_addr_i),
    .kind_i  (req_kind_i),
    .block_o (dec_block)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Loader, request answer, register slave and interrupt in one pass.
  always_comb begin
    nxt_s   = s_ff;
    take    = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    acc     = req_valid_i & s_ff.rdy;
    load    = (s_ff.st == FSG_S_WAIT) & flash_rd_ack_i;
    upset   = '0;
    rd_stat = 1'b0;
    nxt_s.fa = `FSG_CFG_ADDR;
    // fetch the configuration word, then run.
    case (s_ff.st)
      FSG_S_FETCH: begin
        nxt_s.rd = 1'b1;
        nxt_s.st = FSG_S_WAIT;
      end
      FSG_S_WAIT: begin
        if (flash_rd_ack_i) begin
          nxt_s.rd = 1'b0;
          nxt_s.st = FSG_S_RUN;
        end
      end
      FSG_S_RUN: begin
        // a corrupt config is refetched as after a reset.
        if (mism) begin
          nxt_s.st = FSG_S_FETCH;
        end
      end
      default: begin
        nxt_s.st = FSG_S_FETCH;
      end
    endcase
    // Requests are only taken once a trusted config is in place.
    nxt_s.rdy = (nxt_s.st == FSG_S_RUN) & ~mism;
    // answer every taken request one cycle later.
    nxt_s.done = acc;
    nxt_s.blk  = acc & dec_block;
    if (acc && dec_block) begin
      nxt_s.last = req_addr_i;
    end
    // parity error drives the device reset.
    nxt_s.drst = mism;
    ev = '0;
    ev[`FSG_ST_BLK]  = acc & dec_block;
    ev[`FSG_ST_PERR] = mism;
    ev[`FSG_ST_LOAD] = load;
    // Bus access: one ack per strobe, one cycle after it is seen.
    nxt_s.ack = take;
    if (take) begin
      nxt_s.dat = '0;
      if (wb_adr_i == `FSG_REG_CFG) begin
        nxt_s.dat = {16'h0000, cfg};
      end else if (wb_adr_i == `FSG_REG_STAT) begin
        nxt_s.dat = {29'h0, s_ff.stat};
        rd_stat   = ~wb_we_i;
      end else if (wb_adr_i == `FSG_REG_MASK) begin
        nxt_s.dat = {29'h0, s_ff.mask};
        if (wb_we_i && wb_sel_i[0]) begin
          nxt_s.mask = wb_dat_i[`FSG_ST_W-1:0];
        end
      end else if (wb_adr_i == `FSG_REG_UPSET) begin
        if (wb_we_i) begin
          upset[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
          upset[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
        end
      end else if (wb_adr_i == `FSG_REG_LAST) begin
        nxt_s.dat = {15'h0000, s_ff.last};
      end
    end
    // Set wins over the read clear, so no event is lost.
    nxt_s.stat = (rd_stat ? '0 : s_ff.stat) | ev;
    nxt_s.irq  = |(nxt_s.stat & nxt_s.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o     = s_ff.dat;
  assign wb_ack_o     = s_ff.ack;
  assign flash_rd_o   = s_ff.rd;
  assign flash_addr_o = s_ff.fa;
  assign req_ready_o  = s_ff.rdy;
  assign req_done_o   = s_ff.done;
  assign req_block_o  = s_ff.blk;
  assign dev_reset_o  = s_ff.drst;
  assign irq_o        = s_ff.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_req_answer: assert property (
    acc |=> req_done_o ##1 !req_done_o || $past(acc))
    else $error("request not answered");
  a_seg_high: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && cfg[`FSG_BSEL_BIT] &&
     req_kind_i != FSG_EXT_RD &&
     fsg_page(req_addr_i) >= cfg[`FSG_PTR_W-1:0]) |=> req_block_o)
    else $error("upper segment write not blocked");
  a_seg_low: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && !cfg[`FSG_BSEL_BIT] &&
     req_kind_i != FSG_EXT_RD &&
     fsg_page(req_addr_i) <= cfg[`FSG_PTR_W-1:0]) |=> req_block_o)
    else $error("lower segment write not blocked");
  a_last_page: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && !cfg[`FSG_BSEL_BIT] &&
     !cfg[`FSG_LPG_BIT] && req_kind_i != FSG_EXT_RD &&
     fsg_page(req_addr_i) == `FSG_LAST_PAGE) |=> req_block_o)
    else $error("last page write not blocked");
  a_write_guard: assert property (
    (acc && req_kind_i == FSG_INT_WR && !cfg[`FSG_WG_BIT])
    |=> req_done_o && req_block_o)
    else $error("write guard ignored");
  a_seg_off: assert property (
    (acc && req_kind_i == FSG_INT_WR && cfg[`FSG_OFF_BIT] &&
     cfg[`FSG_WG_BIT] && req_addr_i != `FSG_CFG_ADDR) |=> !req_block_o)
    else $error("segment off still blocks");
  a_ext_access: assert property (
    (acc && req_kind_i != FSG_INT_WR && cfg[`FSG_RG_BIT])
    |=> req_block_o)
    else $error("external access not blocked");
  a_cfg_source: assert property (
    (acc && cfg[`FSG_RG_BIT] && req_addr_i == `FSG_CFG_ADDR &&
     req_kind_i != FSG_EXT_RD) |=> req_block_o)
    else $error("config word write not blocked");
  a_parity_rst: assert property (
    mism |=> dev_reset_o && !req_ready_o && s_ff.stat[`FSG_ST_PERR])
    else $error("parity error did not reset");

  // ----------------------------------------------------------------------
  // Further checks on loading, recovery and range ends
  // ----------------------------------------------------------------------
  // pointer page inside
  a_ptr_page: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && req_kind_i != FSG_EXT_RD &&
     fsg_page(req_addr_i) == cfg[`FSG_PTR_W-1:0]) |=> req_block_o)
    else $error("pointer page not protected");
  a_seg_adds: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && !cfg[`FSG_WG_BIT] &&
     req_kind_i == FSG_INT_WR) |=> req_block_o)
    else $error("segment lifted the write guard");
  a_fetch_addr: assert property (
    flash_rd_o |-> flash_addr_o == `FSG_CFG_ADDR)
    else $error("fetch not aimed at config word");
  a_load_flag: assert property (
    load |=> s_ff.stat[`FSG_ST_LOAD] && !flash_rd_o)
    else $error("config load not recorded");
  a_fetch_busy: assert property (
    flash_rd_o |-> !req_ready_o)
    else $error("requests open during fetch");
  a_blk_event: assert property (
    (acc && dec_block) |=> s_ff.stat[`FSG_ST_BLK])
    else $error("block event not recorded");
  a_last_addr: assert property (
    (acc && dec_block) |=> s_ff.last == $past(req_addr_i))
    else $error("blocked address not kept");
  a_refetch: assert property (
    (mism && s_ff.st == FSG_S_RUN) |=> ##1 flash_rd_o)
    else $error("config not fetched again");
  a_rst_lift: assert property (
    load |=> !mism ##1 !dev_reset_o)
    else $error("device reset held after load");
  a_high_cfg: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && cfg[`FSG_BSEL_BIT] &&
     req_kind_i != FSG_EXT_RD && req_addr_i == `FSG_CFG_ADDR)
    |=> req_block_o)
    else $error("upper range left config word open");
  a_last_cfg: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && !cfg[`FSG_BSEL_BIT] &&
     !cfg[`FSG_LPG_BIT] && req_kind_i != FSG_EXT_RD &&
     req_addr_i == `FSG_CFG_ADDR) |=> req_block_o)
    else $error("last page left config word open");
  a_low_only: assert property (
    (acc && !cfg[`FSG_OFF_BIT] && !cfg[`FSG_BSEL_BIT] &&
     cfg[`FSG_LPG_BIT] && cfg[`FSG_WG_BIT] && !cfg[`FSG_RG_BIT] &&
     req_kind_i == FSG_INT_WR &&
     fsg_page(req_addr_i) > cfg[`FSG_PTR_W-1:0]) |=> !req_block_o)
    else $error("write above lower segment blocked");
  a_ext_read: assert property (
    (acc && req_kind_i == FSG_EXT_RD && !cfg[`FSG_RG_BIT])
    |=> req_done_o && !req_block_o)
    else $error("external read blocked without guard");

endmodule : fsg_guard
`default_nettype wire

// File: tb/fsg_flash_model.sv
// Flash model: answers config word fetches and counts permitted requests.
`timescale 1ns/100ps
`default_nettype none
module fsg_flash_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [15:0] word_i,
  input  wire logic        done_i,
  input  wire logic        block_i,
  output logic             ack_o,
  output logic      [15:0] data_o,
  output int               applied_o
);
  initial begin
    ack_o = 1'b0;
    data_o = 16'h0;
    applied_o = 0;
  end

  // config word source
  // Outside the ack the data shows the inverse, so stale data cannot match.
  always begin : fetch
    @(posedge clk_i);
    if (rd_i === 1'b1) begin
      repeat (delay_i) @(posedge clk_i);
      ack_o  <= 1'b1;
      data_o <= word_i;
      @(posedge clk_i);
      ack_o  <= 1'b0;
      data_o <= ~word_i;
    end
  end : fetch

  always @(posedge clk_i) begin
    if (done_i === 1'b1 && block_i === 1'b0) begin
      applied_o <= applied_o + 1;
    end
  end
endmodule : fsg_flash_model
`default_nettype wire

// File: tb/test_fsg_guard.sv
// Self-checking bench of the flash segment write guard.
`timescale 1ns/100ps
`default_nettype none
`include "fsg_cfg.svh"
module test_fsg_guard;
  import fsg_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, f_rd, f_ack;
  logic        valid, ready, done, blk, dev_rst, irq, mask_on;
  logic [3:0]  sel, delay;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [16:0] f_adr, raddr;
  logic [15:0] f_dat, word;
  logic [1:0]  kind;
  logic [2:0]  exp_st;
  logic [16:0] last_blk;
  int          applied, err_count, n_tests, seed, n_perm;
  logic [31:0] rd_q[$];
  logic        blk_q[$];
  localparam logic [4:0] MODES [7] = '{5'b01100, 5'b01001, 5'b01010,
    5'b01000, 5'b00100, 5'b11100, 5'b10000};

  fsg_guard DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_rd_o(f_rd),
    .flash_addr_o(f_adr), .flash_rd_ack_i(f_ack), .flash_rd_data_i(f_dat),
    .req_valid_i(valid), .req_addr_i(raddr), .req_kind_i(kind),
    .req_ready_o(ready), .req_done_o(done), .req_block_o(blk),
    .dev_reset_o(dev_rst), .irq_o(irq));
  fsg_flash_model flash (.clk_i(clk_i), .rd_i(f_rd), .delay_i(delay),
    .word_i(word), .done_i(done), .block_i(blk), .ack_o(f_ack),
    .data_o(f_dat), .applied_o(applied));

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic give_up(input string nm);
    err_count++;
    $display("[ERR] %s expected answer seen timeout", nm);
    complete_run();
  endtask : give_up

  // Independent decision model; segment bits can only add blocking.
  function automatic logic fexp(input logic [15:0] c, input logic [16:0] a,
                                input logic [1:0] k);
    logic [7:0] pg;
    logic       b;
    pg = a[16:9];
    b = c[12] && k != 2'h0;
    if (k != 2'h2) begin
      b |= !c[11] && k == 2'h0;
      b |= c[12] && a == 17'h1ffff;
      if (!c[10]) begin
        b |= c[8] ? pg >= c[7:0] : pg <= c[7:0] || (!c[9] && pg == 8'hff);
      end
    end
    return b;
  endfunction : fexp

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) give_up("wb_ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wb_read(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb_xfer(1'b0, a, 32'h0, 4'hf);
  endtask : wb_read

  // Valid stays up between calls, so requests go back to back.
  task automatic send(input logic [16:0] a, input logic [1:0] k);
    logic e;
    int   n;
    e = fexp(word, a, k);
    valid <= 1'b1;
    raddr <= a;
    kind  <= k;
    blk_q.push_back(e);
    exp_st[0] |= e;
    n_perm += !e;
    if (e) last_blk = a;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready !== 1'b1 && n < 50);
    if (n >= 50) give_up("req_ready");
  endtask : send

  task automatic wait_hi(input bit rdy);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((rdy ? ready : dev_rst) !== 1'b1 && n < 100);
    if (n >= 100) give_up("wait_hi");
  endtask : wait_hi

  // ----------------------------------------------------------------------
  // Monitor: takes the oldest note whenever a result appears
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin : mon
    if (ack === 1'b1 && we === 1'b0) begin
      check("wb_rd", rdat, rd_q.pop_front());
    end
    if (done === 1'b1) begin
      check("block", {31'h0, blk}, {31'h0, blk_q.pop_front()});
    end
    if (f_rd === 1'b1) begin
      check("fetch_adr", {15'h0, f_adr}, {15'h0, `FSG_CFG_ADDR});
    end
  end : mon

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin : watchdog
    repeat (60000) @(posedge clk_i);
    give_up("run");
  end : watchdog

  initial begin : main
    logic [16:0] pts [8];
    logic [7:0]  ptr;
    seed = 32'h1845dca3;
    {err_count, n_tests, n_perm, exp_st, mask_on, last_blk} = '0;
    {rst_i, cyc, stb, we, adr, wdat, sel, valid, raddr, kind} = '0;
    rst_i = 1'b1;
    delay = 4'h3;
    word = 16'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      ptr = (i == 1) ? 8'h00 : 8'($random(seed));
      word <= {3'h0, MODES[i], ptr};
      delay <= 4'($random(seed));
      if (i > 0) begin
        wb_xfer(1'b1, `FSG_REG_UPSET, {$random(seed)} | 32'h1, 4'h3);
        wait_hi(1'b0);
        exp_st[1] = 1'b1;
      end
      wait_hi(1'b1);
      exp_st[2] = 1'b1;
      check("dev_reset", {31'h0, dev_rst}, 32'h0);
      wb_read(`FSG_REG_CFG, {16'h0, word});
      pts = '{17'h0, {ptr, 9'h0}, {ptr, 9'h1ff}, {ptr + 8'h1, 9'h0},
              {ptr - 8'h1, 9'h1ff}, 17'h1fe00, 17'h1ffff,
              17'($random(seed))};
      for (int j = 0; j < 8; j++) begin
        for (int k = 0; k < 4; k++) begin
          send(pts[j], 2'(k));
        end
      end
      valid <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("irq", {31'h0, irq}, {31'h0, mask_on});
      if (i == 1) begin
        wb_xfer(1'b1, `FSG_REG_MASK, 32'h7, 4'h1);
        mask_on = 1'b1;
        wb_read(`FSG_REG_MASK, 32'h7);
        check("irq_on", {31'h0, irq}, 32'h1);
      end
      wb_read(`FSG_REG_STAT, {29'h0, exp_st});
      exp_st = 3'h0;
      repeat (3) @(posedge clk_i);
      check("irq_clr", {31'h0, irq}, 32'h0);
      $display("test %0d done", i);
    end
    wb_read(8'h14, 32'h0);
    wb_read(`FSG_REG_LAST, {15'h0, last_blk});
    check("applied", 32'(applied), 32'(n_perm));
    complete_run();
  end : main
endmodule : test_fsg_guard
`default_nettype wire
